// >>> rbx_expander_top.sv
// receive slot capture, robbed-bit frame detection and companded expansion
// assumes pcm_clk_in is the highway clock and that frame sync, receive data
// and tx_pcm_word_in change on its rising edge; configuration is static
// while frames run
`timescale 1ns/1ps
`include "rbx_consts.svh"

// How it works
// - Robbed-bit handling works only while robbed_frame_enable_in is set.
// - Robbed-bit handling applies only in mu-law, not A-law or linear.
// - The transmit path is untouched and always sends the whole slot word, 8 bits companded or 16 bits linear.
// - A robbed-bit frame drops the received LSB and uses half its weight.
// - Only the receive slot of a robbed-bit frame gets the substitution.
// - Robbed when enabled, mu-law and a two-cycle pulse does not follow another.
// - Sync is sampled on falling edges; high, high then low is two cycles.
// - Other companded frames give the expander all eight received bits unchanged.
// - The robbed bits themselves are never extracted, stored or acted on.
// - The sync pulse marks receive slot 0; all slots count from it.
module rbx_expander_top
	import rbx_pkg::*;
#(
	parameter int BUF_DEPTH = 2
) (
	input wire logic clk_in,
	input wire logic reset_n_in,
	input wire logic pcm_clk_in,
	input wire logic frame_sync_in,
	input wire logic pcm_rx_in,
	output logic pcm_tx_out,
	output logic pcm_tx_oe_n_out,
	input wire logic [15:0] tx_pcm_word_in,
	input wire logic robbed_frame_enable_in,
	input wire logic [1:0] coding_mode_in,
	input wire logic [6:0] rx_slot_in,
	input wire logic [2:0] rx_clock_slot_in,
	input wire logic [6:0] tx_slot_in,
	input wire logic [2:0] tx_clock_slot_in,
	output logic [15:0] sample_out,
	output logic sample_robbed_out,
	output logic sample_valid_out,
	input wire logic sample_ready_in
);

	// bit position of a slot counted from the frame sync edge
	function automatic logic [10:0] slot_base(input logic [6:0] slot,
			input logic [2:0] clk_slot);
		slot_base = {1'b0, slot, 3'b000} + {8'h00, clk_slot};
	endfunction

	// companded byte to signed linear sample, optional half-LSB
	function automatic logic [15:0] expand(input logic [7:0] code,
			input logic mulaw, input logic half);
		logic [7:0] c;
		logic [15:0] term;
		logic [15:0] mag;
		logic neg;
		c = mulaw ? ~code : (code ^ `RBX_A_XOR);
		// mantissa lsb weighs 4; a robbed lsb is replaced by 2, half of it
		if (half) begin
			term = {`RBX_TERM_PAD, c[3:1], `RBX_HALF_LSB};
		end else begin
			term = {`RBX_TERM_PAD, c[3:0], `RBX_LSB_PAD};
		end
		if (mulaw) begin
			mag = ((term + `RBX_EXP_BIAS) << c[6:4]) - `RBX_EXP_BIAS;
			mag = mag << `RBX_MU_ALIGN;
			neg = c[7];
		end else begin
			if (c[6:4] == `RBX_EXP_ZERO) begin
				mag = term + `RBX_SEG0_ADD;
			end else begin
				mag = (term + `RBX_EXP_BIAS) << (c[6:4] - `RBX_EXP_ONE);
			end
			mag = mag << `RBX_A_ALIGN;
			neg = ~c[7];
		end
		expand = neg ? (16'h0000 - mag) : mag;
	endfunction

	// ---------------- link domain, falling edge of the PCM clock ----------
	logic pcm_clk_n;
	rbx_cfg_s cfg_raw;
	rbx_cfg_s cfg_link;
	logic [RBX_CFG_W-1:0] cfg_link_bits;

	assign pcm_clk_n = ~pcm_clk_in;
	assign cfg_raw.enable = robbed_frame_enable_in;
	assign cfg_raw.mode = rbx_code_e'(coding_mode_in);
	assign cfg_raw.rx_slot = rx_slot_in;
	assign cfg_raw.rx_clk_slot = rx_clock_slot_in;
	assign cfg_raw.tx_slot = tx_slot_in;
	assign cfg_raw.tx_clk_slot = tx_clock_slot_in;

	rbx_sync3 #(
		.WIDTH(RBX_CFG_W)
	) u_cfg_sync (
		.clk_in(pcm_clk_n),
		.reset_n_in(reset_n_in),
		.async_in(cfg_raw),
		.sync_out(cfg_link_bits)
	);
	assign cfg_link = rbx_cfg_s'(cfg_link_bits);

	logic fs_prev_r;
	logic [1:0] hi_cnt_r;
	logic prev_two_r;
	logic robbed_r;
	logic in_frame_r;
	logic [10:0] pos_r;
	logic [15:0] rx_shift_r;
	rbx_word_s word_r;
	logic word_tog_r;
	logic tx_bit_r;
	logic tx_oe_n_r;

	logic fs_start;
	logic fs_end;
	logic pulse_two;
	logic is_linear;
	logic [10:0] pos_cur;
	logic [10:0] win_last;
	logic [10:0] rx_off;
	logic [10:0] tx_off;
	logic rx_in_win;
	logic tx_in_win;
	logic [3:0] tx_idx;

	assign fs_start = frame_sync_in & ~fs_prev_r;
	assign fs_end = ~frame_sync_in & fs_prev_r;
	assign pulse_two = (hi_cnt_r == `RBX_HI_TWO);
	assign is_linear = (cfg_link.mode == RBX_LINEAR);
	assign win_last = is_linear ? `RBX_WORD_LAST : `RBX_BYTE_LAST;
	// the sync edge itself is bit 0 of slot 0
	assign pos_cur = fs_start ? `RBX_POS_ZERO :
		((pos_r == `RBX_POS_MAX) ? pos_r : pos_r + 11'h001);
	assign rx_off = pos_cur - slot_base(cfg_link.rx_slot, cfg_link.rx_clk_slot);
	assign tx_off = pos_cur - slot_base(cfg_link.tx_slot, cfg_link.tx_clk_slot);
	assign rx_in_win = (in_frame_r | fs_start) &
		(pos_cur >= slot_base(cfg_link.rx_slot, cfg_link.rx_clk_slot)) &
		(rx_off <= win_last);
	assign tx_in_win = (in_frame_r | fs_start) &
		(pos_cur >= slot_base(cfg_link.tx_slot, cfg_link.tx_clk_slot)) &
		(tx_off <= win_last);
	assign tx_idx = 4'(win_last - tx_off);

	// length of the current sync pulse in falling edges
	always_ff @(posedge pcm_clk_n or negedge reset_n_in) begin
		if (!reset_n_in) begin
			fs_prev_r <= 1'b0;
			hi_cnt_r <= 2'h0;
		end else begin
			fs_prev_r <= frame_sync_in;
			if (fs_start) begin
				hi_cnt_r <= `RBX_HI_ONE;
			end else if (frame_sync_in && hi_cnt_r != `RBX_HI_MAX) begin
				hi_cnt_r <= hi_cnt_r + `RBX_HI_ONE;
			end else if (!frame_sync_in) begin
				hi_cnt_r <= 2'h0;
			end
		end
	end

	// frame classification, decided on the edge that sees sync low again
	always_ff @(posedge pcm_clk_n or negedge reset_n_in) begin
		if (!reset_n_in) begin
			prev_two_r <= 1'b0;
			robbed_r <= 1'b0;
		end else if (fs_start) begin
			robbed_r <= 1'b0;
		end else if (fs_end) begin
			robbed_r <= cfg_link.enable & (cfg_link.mode == RBX_MULAW) &
				pulse_two & ~prev_two_r;
			prev_two_r <= pulse_two;
		end
	end

	// bit position within the frame
	always_ff @(posedge pcm_clk_n or negedge reset_n_in) begin
		if (!reset_n_in) begin
			pos_r <= `RBX_POS_ZERO;
			in_frame_r <= 1'b0;
		end else begin
			pos_r <= pos_cur;
			if (fs_start) begin
				in_frame_r <= 1'b1;
			end
		end
	end

	// receive slot capture and hand-off toward the system clock
	always_ff @(posedge pcm_clk_n or negedge reset_n_in) begin
		if (!reset_n_in) begin
			rx_shift_r <= 16'h0000;
			word_r <= '0;
			word_tog_r <= 1'b0;
		end else if (rx_in_win) begin
			rx_shift_r <= {rx_shift_r[14:0], pcm_rx_in};
			if (rx_off == win_last) begin
				// only a flag travels with the byte; the bit is not kept apart
				word_r.robbed <= robbed_r;
				word_r.mode <= cfg_link.mode;
				word_r.data <= {rx_shift_r[14:0], pcm_rx_in};
				word_tog_r <= ~word_tog_r;
			end
		end
	end

	// transmit slot, all bits sent whatever the robbed-bit setting
	always_ff @(posedge pcm_clk_n or negedge reset_n_in) begin
		if (!reset_n_in) begin
			tx_bit_r <= 1'b0;
			tx_oe_n_r <= 1'b1;
		end else begin
			tx_oe_n_r <= ~tx_in_win;
			if (tx_in_win) begin
				tx_bit_r <= tx_pcm_word_in[tx_idx];
			end
		end
	end

	assign pcm_tx_out = tx_bit_r;
	assign pcm_tx_oe_n_out = tx_oe_n_r;

	// ---------------- system domain ---------------------------------------
	logic tog_sys;
	logic tog_seen_r;
	logic push_valid;
	logic push_ready;
	logic pop_valid;
	logic pop_ready;
	logic [RBX_WORD_W-1:0] pop_bits;
	rbx_word_s pop_word;
	logic [15:0] sample_r;
	logic sample_robbed_r;
	logic sample_valid_r;

	rbx_sync3 #(
		.WIDTH(1)
	) u_tog_sync (
		.clk_in(clk_in),
		.reset_n_in(reset_n_in),
		.async_in(word_tog_r),
		.sync_out(tog_sys)
	);

	// word_r has been stable for over three clk_in cycles once the toggle lands
	assign push_valid = (tog_sys != tog_seen_r);

	always_ff @(posedge clk_in or negedge reset_n_in) begin
		if (!reset_n_in) begin
			tog_seen_r <= 1'b0;
		end else if (push_valid && push_ready) begin
			tog_seen_r <= tog_sys;
		end
	end

	rbx_buf2 #(
		.WIDTH(RBX_WORD_W),
		.DEPTH(BUF_DEPTH)
	) u_buf (
		.clk_in(clk_in),
		.reset_n_in(reset_n_in),
		.in_valid_in(push_valid),
		.in_ready_out(push_ready),
		.in_data_in(word_r),
		.out_valid_out(pop_valid),
		.out_ready_in(pop_ready),
		.out_data_out(pop_bits)
	);

	assign pop_word = rbx_word_s'(pop_bits);
	assign pop_ready = ~sample_valid_r | sample_ready_in;

	// expander stage
	always_ff @(posedge clk_in or negedge reset_n_in) begin
		if (!reset_n_in) begin
			sample_r <= 16'h0000;
			sample_robbed_r <= 1'b0;
		end else if (pop_valid && pop_ready) begin
			sample_robbed_r <= pop_word.robbed;
			if (pop_word.mode == RBX_LINEAR) begin
				sample_r <= pop_word.data;
			end else begin
				sample_r <= expand(pop_word.data[7:0],
					pop_word.mode == RBX_MULAW,
					pop_word.robbed);
			end
		end
	end

	always_ff @(posedge clk_in or negedge reset_n_in) begin
		if (!reset_n_in) begin
			sample_valid_r <= 1'b0;
		end else if (pop_ready) begin
			sample_valid_r <= pop_valid;
		end
	end

	assign sample_out = sample_r;
	assign sample_robbed_out = sample_robbed_r;
	assign sample_valid_out = sample_valid_r;

endmodule

// >>> rbx_consts.svh
// constants for the robbed-bit receive expander
// assumes inclusion by bare name from every design file that needs it
`ifndef RBX_CONSTS_SVH
`define RBX_CONSTS_SVH

`define RBX_POS_ZERO 11'h000
`define RBX_POS_MAX 11'h7ff
`define RBX_HI_ONE 2'h1
`define RBX_HI_TWO 2'h2
`define RBX_HI_MAX 2'h3
`define RBX_BYTE_LAST 11'h007
`define RBX_WORD_LAST 11'h00f
`define RBX_A_XOR 8'h55
`define RBX_EXP_BIAS 16'h0042
`define RBX_SEG0_ADD 16'h0002
`define RBX_HALF_LSB 3'h2
`define RBX_LSB_PAD 2'h0
`define RBX_TERM_PAD 10'h000
`define RBX_EXP_ONE 3'h1
`define RBX_EXP_ZERO 3'h0
`define RBX_MU_ALIGN 1
`define RBX_A_ALIGN 2

`endif

// >>> rbx_pkg.sv
// types shared by the robbed-bit receive expander files
// assumes nothing beyond a SystemVerilog compiler
package rbx_pkg;

	typedef enum logic [1:0] {
		RBX_ALAW = 2'b00,
		RBX_MULAW = 2'b01,
		RBX_LINEAR = 2'b10
	} rbx_code_e;

	// one received slot word handed from the link to the system side
	typedef struct packed {
		logic robbed;
		rbx_code_e mode;
		logic [15:0] data;
	} rbx_word_s;

	// static configuration carried into the link domain
	typedef struct packed {
		logic enable;
		rbx_code_e mode;
		logic [6:0] rx_slot;
		logic [2:0] rx_clk_slot;
		logic [6:0] tx_slot;
		logic [2:0] tx_clk_slot;
	} rbx_cfg_s;

	localparam int RBX_WORD_W = $bits(rbx_word_s);
	localparam int RBX_CFG_W = $bits(rbx_cfg_s);

endpackage

// >>> rbx_sync3.sv
// three-flop synchroniser; output follows once stages two and three agree
// assumes the source vector is quasi-static or a single toggle
`timescale 1ns/1ps

module rbx_sync3 #(
	parameter int WIDTH = 1
) (
	input wire logic clk_in,
	input wire logic reset_n_in,
	input wire logic [WIDTH-1:0] async_in,
	output logic [WIDTH-1:0] sync_out
);

	logic [WIDTH-1:0] meta_r;
	logic [WIDTH-1:0] stage2_r;
	logic [WIDTH-1:0] stage3_r;
	logic [WIDTH-1:0] sync_r;

	always_ff @(posedge clk_in or negedge reset_n_in) begin
		if (!reset_n_in) begin
			meta_r <= '0;
			stage2_r <= '0;
			stage3_r <= '0;
		end else begin
			meta_r <= async_in;
			stage2_r <= meta_r;
			stage3_r <= stage2_r;
		end
	end

	always_ff @(posedge clk_in or negedge reset_n_in) begin
		if (!reset_n_in) begin
			sync_r <= '0;
		end else if (stage2_r == stage3_r) begin
			sync_r <= stage3_r;
		end
	end

	assign sync_out = sync_r;

endmodule

// >>> rbx_buf2.sv
// small valid/ready buffer, two entries by default
// assumes DEPTH is a power of two and both sides share one clock
`timescale 1ns/1ps

module rbx_buf2 #(
	parameter int WIDTH = 8,
	parameter int DEPTH = 2
) (
	input wire logic clk_in,
	input wire logic reset_n_in,
	input wire logic in_valid_in,
	output logic in_ready_out,
	input wire logic [WIDTH-1:0] in_data_in,
	output logic out_valid_out,
	input wire logic out_ready_in,
	output logic [WIDTH-1:0] out_data_out
);

	localparam int PW = (DEPTH > 1) ? $clog2(DEPTH) : 1;
	localparam int CW = $clog2(DEPTH + 1);

	logic [WIDTH-1:0] mem_r [DEPTH];
	logic [PW-1:0] wr_ptr_r;
	logic [PW-1:0] rd_ptr_r;
	logic [CW-1:0] count_r;
	logic push;
	logic pop;

	assign in_ready_out = (count_r != CW'(DEPTH));
	assign out_valid_out = (count_r != '0);
	assign push = in_valid_in & in_ready_out;
	assign pop = out_valid_out & out_ready_in;
	assign out_data_out = mem_r[rd_ptr_r];

	always_ff @(posedge clk_in) begin
		if (push) begin
			mem_r[wr_ptr_r] <= in_data_in;
		end
	end

	always_ff @(posedge clk_in or negedge reset_n_in) begin
		if (!reset_n_in) begin
			wr_ptr_r <= '0;
			rd_ptr_r <= '0;
			count_r <= '0;
		end else begin
			if (push) begin
				wr_ptr_r <= wr_ptr_r + PW'(1);
			end
			if (pop) begin
				rd_ptr_r <= rd_ptr_r + PW'(1);
			end
			if (push && !pop) begin
				count_r <= count_r + CW'(1);
			end else if (pop && !push) begin
				count_r <= count_r - CW'(1);
			end
		end
	end

endmodule

// >>> rbx_expander_top_monitor.sv
// checker on the ports of the robbed-bit receive expander
// assumes it is bound to rbx_expander_top, link logic on falling pcm edges
`timescale 1ns/1ps
module rbx_expander_top_monitor
	import rbx_pkg::*;
#(
	parameter int BUF_DEPTH = 2
) (
	input wire logic clk_in,
	input wire logic reset_n_in,
	input wire logic pcm_clk_in,
	input wire logic frame_sync_in,
	input wire logic pcm_tx_out,
	input wire logic pcm_tx_oe_n_out,
	input wire logic [15:0] tx_pcm_word_in,
	input wire logic robbed_frame_enable_in,
	input wire logic [1:0] coding_mode_in,
	input wire logic [6:0] tx_slot_in,
	input wire logic [2:0] tx_clock_slot_in,
	input wire logic [15:0] sample_out,
	input wire logic sample_robbed_out,
	input wire logic sample_valid_out,
	input wire logic sample_ready_in
);
	logic fs_r;
	logic [10:0] pos_r;
	logic [10:0] bit_w;
	logic lin_w;
	logic rob_w;
	// index inside the tx slot of the bit now on the line
	assign bit_w = pos_r - {1'b0, tx_slot_in, tx_clock_slot_in} - 11'h001;
	assign lin_w = coding_mode_in == RBX_LINEAR;
	assign rob_w = sample_valid_out && sample_robbed_out;
	always_ff @(negedge pcm_clk_in or negedge reset_n_in) begin
		if (!reset_n_in) begin
			fs_r <= 1'b0;
			pos_r <= 11'h000;
		end else begin
			fs_r <= frame_sync_in;
			pos_r <= (frame_sync_in && !fs_r) ? 11'h001 : pos_r + 11'h001;
		end
	end
	sequence s_low8;
		!pcm_tx_oe_n_out [*8];
	endsequence
	a_rob_en: assert property (
		@(posedge clk_in) disable iff (!reset_n_in)
		rob_w |-> robbed_frame_enable_in) else $error("robbed while off");
	a_rob_mulaw: assert property (
		@(posedge clk_in) disable iff (!reset_n_in)
		rob_w |-> coding_mode_in == RBX_MULAW) else $error("robbed not mu");
	a_rob_half: assert property (
		@(posedge clk_in) disable iff (!reset_n_in)
		rob_w |-> sample_out[2:0] == 3'h4) else $error("no half lsb");
	a_hold_word: assert property (
		@(posedge clk_in) disable iff (!reset_n_in)
		sample_valid_out && !sample_ready_in |=> sample_valid_out
		&& $stable(sample_out) && $stable(sample_robbed_out))
		else $error("sample changed while stalled");
	a_tx_start: assert property (
		@(negedge pcm_clk_in) disable iff (!reset_n_in)
		$fell(pcm_tx_oe_n_out) |-> bit_w == 11'h000)
		else $error("tx slot misplaced");
	a_tx_byte: assert property (
		@(negedge pcm_clk_in) disable iff (!reset_n_in)
		$fell(pcm_tx_oe_n_out) && !lin_w |-> s_low8 ##1 pcm_tx_oe_n_out)
		else $error("tx byte length");
	a_tx_word: assert property (
		@(negedge pcm_clk_in) disable iff (!reset_n_in)
		$fell(pcm_tx_oe_n_out) && lin_w |-> s_low8 ##1 s_low8
		##1 pcm_tx_oe_n_out) else $error("tx word length");
	a_tx_bits: assert property (
		@(negedge pcm_clk_in) disable iff (!reset_n_in)
		!pcm_tx_oe_n_out |-> pcm_tx_out ==
		tx_pcm_word_in[(lin_w ? 4'hf : 4'h7) - bit_w[3:0]])
		else $error("tx bit wrong");
endmodule

bind rbx_expander_top rbx_expander_top_monitor #(.BUF_DEPTH(BUF_DEPTH)) mon (
	.clk_in(clk_in), .reset_n_in(reset_n_in), .pcm_clk_in(pcm_clk_in),
	.frame_sync_in(frame_sync_in), .pcm_tx_out(pcm_tx_out),
	.pcm_tx_oe_n_out(pcm_tx_oe_n_out), .tx_pcm_word_in(tx_pcm_word_in),
	.robbed_frame_enable_in(robbed_frame_enable_in),
	.coding_mode_in(coding_mode_in), .tx_slot_in(tx_slot_in),
	.tx_clock_slot_in(tx_clock_slot_in), .sample_out(sample_out),
	.sample_robbed_out(sample_robbed_out),
	.sample_valid_out(sample_valid_out), .sample_ready_in(sample_ready_in));

// >>> rbx_hw_src.sv
// behavioural pcm highway source: free pcm clock, frame sync, rx bits
// assumes the expander samples on falling pcm edges
`timescale 1ns/1ps
module rbx_hw_src (
	output logic pcm_clk_out,
	output logic frame_sync_out,
	output logic pcm_rx_out
);
	initial begin
		pcm_clk_out = 1'b0;
		frame_sync_out = 1'b0;
		pcm_rx_out = 1'b0;
		#7;
		forever #40 pcm_clk_out = ~pcm_clk_out;
	end
	// released data line toggles so stale bits never look valid
	task idle(input int n);
		repeat (n) begin
			@(posedge pcm_clk_out);
			pcm_rx_out = ~pcm_rx_out;
		end
	endtask
	// one 40-bit frame; pulse length marks robbed frames
	task frame(input int len, input int d, input int nb, input int base);
		for (int p = 0; p < 40; p++) begin
			@(posedge pcm_clk_out);
			frame_sync_out = p < len;
			if (p >= base && p < base + nb)
				pcm_rx_out = d[nb - 1 - p + base];
			else
				pcm_rx_out = ~pcm_rx_out;
		end
	endtask
endmodule

// >>> testbench.sv
// self-checking bench for rbx_expander_top with a pcm highway source
// assumes the source model and the bound checker are compiled first
`timescale 1ns/1ps
module testbench;
	import rbx_pkg::*;
	logic clk_in = 1'b0;
	logic reset_n_in = 1'b0;
	logic rdy = 1'b0;
	logic en = 1'b0;
	logic [1:0] md = 2'h0;
	logic [2:0] rcs = 3'h0;
	logic [6:0] rts = 7'h00;
	logic [2:0] tcs = 3'h0;
	logic [15:0] txw = 16'h0000;
	logic pclk, fs, rx, tx, oe_n, sr, sv;
	logic [15:0] so;
	int err_total = 0;
	int comparisons = 0;
	int seed = 32'h0000_f175;
	int prev2 = 0;
	int q[$];
	// pulse length, mode, enable as three digits
	int tbl[12] = '{211, 211, 111, 211, 311, 211,
		110, 210, 101, 201, 121, 221};
	always #10 clk_in = ~clk_in;
	always @(negedge clk_in)
		rdy <= $random(seed);
	rbx_hw_src hw (.pcm_clk_out(pclk), .frame_sync_out(fs),
		.pcm_rx_out(rx));
	rbx_expander_top #(.BUF_DEPTH(2)) uut (.clk_in(clk_in),
		.reset_n_in(reset_n_in), .pcm_clk_in(pclk), .frame_sync_in(fs),
		.pcm_rx_in(rx), .pcm_tx_out(tx), .pcm_tx_oe_n_out(oe_n),
		.tx_pcm_word_in(txw), .robbed_frame_enable_in(en),
		.coding_mode_in(md), .rx_slot_in(rts), .rx_clock_slot_in(rcs),
		.tx_slot_in(7'h02), .tx_clock_slot_in(tcs), .sample_out(so),
		.sample_robbed_out(sr), .sample_valid_out(sv),
		.sample_ready_in(rdy));
	function automatic int expand(int b, int m, int rob);
		int c, e, t, g;
		c = m == 1 ? ~b & 8'hff : b ^ 8'h55;
		e = c >> 4 & 7;
		t = rob ? 8 * (c >> 1 & 7) + 2 : 4 * (c & 15);
		if (m == 2)
			g = b;
		else if (m == 1)
			g = (((t + 66) << e) - 66) * 2 * (c & 8'h80 ? -1 : 1);
		else
			g = (e ? (t + 66) << e - 1 : t + 2) * 4 * (c & 8'h80 ? 1 : -1);
		return g & 16'hffff;
	endfunction
	function automatic int rnd(int n);
		return {$random(seed)} % n;
	endfunction
	task chk(input logic [16:0] got, input logic [16:0] exp);
		comparisons++;
		if (got !== exp) begin
			err_total++;
			$display("[ERR] %0t sample %h expected %h", $time, got, exp);
		end
	endtask
	task stop_test;
		$display("mismatches %0d comparisons %0d", err_total, comparisons);
		if (err_total == 0 && comparisons > 0)
			$display("Testbench passed");
		else
			$display("Testbench failed");
		$finish;
	endtask
	always @(posedge clk_in)
		if (sv === 1'b1 && rdy === 1'b1)
			chk({sr, so}, q.size() > 0 ? q.pop_front() : -1);
	task run(input int len, input int m, input int e);
		int b, rob, i;
		@(negedge clk_in);
		md = m[1:0];
		en = e[0];
		rcs = $random(seed);
		rts = 7'(rnd(2));
		tcs = $random(seed);
		txw = $random(seed);
		b = $random(seed) & (m == 2 ? 16'hffff : 16'h00ff);
		rob = e && m == 1 && len == 2 && !prev2;
		prev2 = len == 2;
		q.push_back(rob * 65536 + expand(b, m, rob));
		hw.idle(6);
		hw.frame(len, b, m == 2 ? 16 : 8, 8 * rts + rcs);
		for (i = 0; i < 400 && q.size() > 0; i++)
			@(posedge clk_in);
		if (q.size() > 0) begin
			err_total++;
			$display("[ERR] %0t no sample delivered", $time);
			stop_test;
		end
	endtask
	initial begin
		repeat (2) @(negedge clk_in);
		reset_n_in = 1'b1;
		foreach (tbl[k])
			run(tbl[k] / 100, tbl[k] / 10 % 10, tbl[k] % 10);
		// mid-run reset after a two-cycle pulse: history must be cleared
		@(negedge clk_in);
		reset_n_in = 1'b0;
		prev2 = 0;
		repeat (8) @(negedge clk_in);
		reset_n_in = 1'b1;
		run(2, 1, 1);
		repeat (12)
			run(1 + rnd(3), rnd(3), rnd(2));
		stop_test;
	end
endmodule
